/* File: shared/csx_pkg.sv */
// constants and types for the sleep/swap/subtract/xor execution block
// Overview of operation
// - sleep clears supervision counter and its prescaler
// - sleep: sleep_entry_flag 0, expiry_flag 1 only
// - sleep halts oscillator, no further instructions until wake_i
// - nibble swap exchanges halves, flags untouched
// - destination bit 0 accumulator, 1 file register
// - register xor, routed by destination, zero flag
// - literal xor into accumulator, zero flag only
// - literal minus accumulator, sets carry, digit, zero
package csx_pkg;
  // ****************************************************************
  // opcodes, reset values
  // ****************************************************************
  typedef enum logic [2:0] {
    CSX_OP_NONE = 3'b000,
    CSX_OP_SLEEP = 3'b001,
    CSX_OP_SWAP = 3'b010,
    CSX_OP_SUBL = 3'b011,
    CSX_OP_XORL = 3'b100,
    CSX_OP_XORF = 3'b101
  } csx_op_t;
  localparam logic [7:0] CSX_ACC_RST = 8'h00;
  localparam logic [7:0] CSX_CNT_CLEAR = 8'h00;
  localparam logic CSX_EXPIRY_RST = 1'b1;
  localparam logic CSX_SLEEP_ENTRY_RST = 1'b1;
  localparam logic [7:0] CSX_FWDATA_RST = 8'h00;
  localparam logic [6:0] CSX_FWADDR_RST = 7'h00;
  localparam logic CSX_FLAG_RST = 1'b0;
  localparam logic CSX_PULSE_RST = 1'b0;
  localparam logic CSX_ASLEEP_RST = 1'b0;
  localparam logic CSX_OSC_RUN_RST = 1'b1;
  localparam int CSX_NIB_LO = 0;
  localparam int CSX_NIB_HI = 4;
endpackage

/* File: logic/csx_exec.sv */
// execution datapath for sleep, nibble swap, literal subtract and xor
`timescale 1ns/1ns
module csx_exec
  import csx_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // instruction
  input wire logic valid_i,
  input wire logic [2:0] op_i,
  input wire logic [7:0] lit_i,
  input wire logic dest_i,
  input wire logic [6:0] faddr_i,
  input wire logic [7:0] fdata_i,
  input wire logic wake_i,
  // results
  output logic [7:0] acc_o,
  output logic fwr_o,
  output logic [6:0] fwaddr_o,
  output logic [7:0] fwdata_o,
  output logic carry_o,
  output logic nibble_overflow_bit_o,
  output logic zero_o,
  output logic expiry_flag_o,
  output logic sleep_entry_flag_o,
  output logic cnt_clr_o,
  output logic osc_run_o,
  output logic asleep_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] acc_r, acc_nxt, fwdata_r, fwdata_nxt;
  logic [6:0] fwaddr_r, fwaddr_nxt;
  logic fwr_r, fwr_nxt, c_r, c_nxt, nov_r, nov_nxt, z_r, z_nxt;
  logic exp_r, exp_nxt, ent_r, ent_nxt, clr_r, clr_nxt, slp_r, slp_nxt;
  logic osc_r, osc_nxt;
  logic [7:0] res;
  logic [8:0] diff;
  logic [4:0] ldiff;
  logic go;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  // next-state: asleep core ignores instructions until woken
  always_comb begin
    acc_nxt = acc_r;
    fwdata_nxt = fwdata_r;
    fwaddr_nxt = fwaddr_r;
    fwr_nxt = 1'b0;
    c_nxt = c_r;
    nov_nxt = nov_r;
    z_nxt = z_r;
    exp_nxt = exp_r;
    ent_nxt = ent_r;
    clr_nxt = 1'b0;
    slp_nxt = slp_r & ~wake_i;
    res = 8'h00;
    // borrow-free subtract: carry high means no borrow
    diff = {1'b0, lit_i} + {1'b0, ~acc_r} + 9'h001;
    ldiff = {1'b0, lit_i[3:0]} + {1'b0, ~acc_r[3:0]} + 5'h01;
    go = valid_i & ~slp_r;
    if (go) begin
      unique case (op_i)
        CSX_OP_SLEEP: begin
          clr_nxt = 1'b1;
          exp_nxt = 1'b1;
          ent_nxt = 1'b0;
          slp_nxt = 1'b1;
        end
        CSX_OP_SWAP: begin
          res = {fdata_i[CSX_NIB_LO+:4], fdata_i[CSX_NIB_HI+:4]};
        end
        CSX_OP_SUBL: begin
          res = diff[7:0];
          acc_nxt = res;
          c_nxt = diff[8];
          nov_nxt = ldiff[4];
          z_nxt = is_zero(res);
        end
        CSX_OP_XORL: begin
          res = acc_r ^ lit_i;
          acc_nxt = res;
          z_nxt = is_zero(res);
        end
        CSX_OP_XORF: begin
          res = acc_r ^ fdata_i;
          z_nxt = is_zero(res);
        end
        default: begin
        end
      endcase
      // destination routing for file-register forms
      if (op_i == CSX_OP_SWAP || op_i == CSX_OP_XORF) begin
        if (dest_i) begin
          fwr_nxt = 1'b1;
          fwaddr_nxt = faddr_i;
          fwdata_nxt = res;
        end else begin
          acc_nxt = res;
        end
      end
    end
    // own flop, so the pin carries no inverter glitch
    osc_nxt = ~slp_nxt;
  end

  // registers, reset values kept in the package
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_r <= CSX_ACC_RST;
      fwdata_r <= CSX_FWDATA_RST;
      fwaddr_r <= CSX_FWADDR_RST;
      fwr_r <= CSX_PULSE_RST;
      c_r <= CSX_FLAG_RST;
      nov_r <= CSX_FLAG_RST;
      z_r <= CSX_FLAG_RST;
      exp_r <= CSX_EXPIRY_RST;
      ent_r <= CSX_SLEEP_ENTRY_RST;
      clr_r <= CSX_PULSE_RST;
      slp_r <= CSX_ASLEEP_RST;
      osc_r <= CSX_OSC_RUN_RST;
    end else begin
      acc_r <= acc_nxt;
      fwdata_r <= fwdata_nxt;
      fwaddr_r <= fwaddr_nxt;
      fwr_r <= fwr_nxt;
      c_r <= c_nxt;
      nov_r <= nov_nxt;
      z_r <= z_nxt;
      exp_r <= exp_nxt;
      ent_r <= ent_nxt;
      clr_r <= clr_nxt;
      slp_r <= slp_nxt;
      osc_r <= osc_nxt;
    end
  end

  // outputs straight from registers, no logic after a flop
  assign acc_o = acc_r;
  assign fwr_o = fwr_r;
  assign fwaddr_o = fwaddr_r;
  assign fwdata_o = fwdata_r;
  assign carry_o = c_r;
  assign nibble_overflow_bit_o = nov_r;
  assign zero_o = z_r;
  assign expiry_flag_o = exp_r;
  assign sleep_entry_flag_o = ent_r;
  assign cnt_clr_o = clr_r;
  assign osc_run_o = osc_r;
  assign asleep_o = slp_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic run_c;
  // instruction really taken at this edge
  assign run_c = valid_i & ~slp_r;

  a_sleep_clears_cnt: assert property (
    run_c && op_i == CSX_OP_SLEEP |=> cnt_clr_o)
    else $error("sleep did not clear counter");
  a_sleep_flags: assert property (
    run_c && op_i == CSX_OP_SLEEP |=> expiry_flag_o && !sleep_entry_flag_o
      && $stable(zero_o) && $stable(carry_o))
    else $error("sleep flags wrong");
  a_sleep_halts: assert property (
    asleep_o && !wake_i |=> $stable(acc_o) && !fwr_o && !osc_run_o)
    else $error("instruction ran while asleep");
  a_swap_value: assert property (
    run_c && op_i == CSX_OP_SWAP && dest_i |=> fwr_o
      && fwdata_o == {$past(fdata_i[3:0]), $past(fdata_i[7:4])}
      && $stable(zero_o))
    else $error("swap result wrong");
  a_dest_acc: assert property (
    run_c && op_i == CSX_OP_SWAP && !dest_i |=> !fwr_o
      && acc_o == {$past(fdata_i[3:0]), $past(fdata_i[7:4])})
    else $error("destination routing wrong");
  a_xorf_value: assert property (
    run_c && op_i == CSX_OP_XORF && !dest_i |=>
      acc_o == ($past(acc_o) ^ $past(fdata_i)) && $stable(carry_o))
    else $error("register xor wrong");
  a_xorl_value: assert property (
    run_c && op_i == CSX_OP_XORL |=>
      acc_o == ($past(acc_o) ^ $past(lit_i)) && $stable(carry_o))
    else $error("literal xor wrong");
  a_subl_value: assert property (
    run_c && op_i == CSX_OP_SUBL |=>
      acc_o == 8'($past(lit_i) - $past(acc_o))
      && carry_o == ($past(lit_i) >= $past(acc_o)))
    else $error("literal subtract wrong");
  a_zero_flag: assert property (
    run_c && (op_i == CSX_OP_XORL || op_i == CSX_OP_SUBL) |=>
      zero_o == (acc_o == 8'h00))
    else $error("zero flag wrong");
  a_subl_digit: assert property (
    run_c && op_i == CSX_OP_SUBL |=>
      nibble_overflow_bit_o == ($past(lit_i[3:0]) >= $past(acc_o[3:0])))
    else $error("literal subtract digit flag wrong");
  a_swap_flags: assert property (
    run_c && op_i == CSX_OP_SWAP |=> $stable(carry_o)
      && $stable(nibble_overflow_bit_o) && $stable(zero_o))
    else $error("swap touched a flag");
  a_xorf_file: assert property (
    run_c && op_i == CSX_OP_XORF && dest_i |=> fwr_o && $stable(acc_o)
      && fwdata_o == ($past(acc_o) ^ $past(fdata_i))
      && fwaddr_o == $past(faddr_i) && zero_o == (fwdata_o == 8'h00))
    else $error("register xor to file wrong");
  a_clear_pulse: assert property (
    cnt_clr_o |=> !cnt_clr_o)
    else $error("counter clear held too long");
  a_osc_stopped: assert property (
    osc_run_o == !asleep_o)
    else $error("oscillator state wrong while asleep");

  // main scenarios worth seeing at least once
  c_sleep: cover property (run_c && op_i == CSX_OP_SLEEP ##1 wake_i);
  c_wake_resume: cover property (asleep_o && wake_i ##1 !asleep_o);
  c_sub_borrow: cover property (run_c && op_i == CSX_OP_SUBL ##1 !carry_o);
  c_xor_zero: cover property (run_c && op_i == CSX_OP_XORF ##1 zero_o);
  c_swap_file: cover property (run_c && op_i == CSX_OP_SWAP && dest_i);
endmodule // csx_exec

/* File: verification/tb_top.sv */
// self-checking bench for the csx execution block
`timescale 1ns/1ns
module tb_top;
  import csx_pkg::*;
  // one instruction and what it should leave behind
  typedef struct packed {
    logic [2:0] op;
    logic [7:0] lit;
    logic d;
    logic [7:0] fd;
    logic [7:0] acc;
    logic [2:0] f;
    logic w;
    logic [7:0] wd;
  } csx_row_t;
  logic clk_i = 1'b0;
  logic nrst_i, valid_i, dest_i, wake_i;
  logic [2:0] op_i;
  logic [7:0] lit_i, fdata_i;
  logic [6:0] faddr_i;
  logic [7:0] acc_o, fwdata_o, st;
  logic [6:0] fwaddr_o;
  logic fwr_o, carry_o, nibble_overflow_bit_o, zero_o, expiry_flag_o;
  logic sleep_entry_flag_o, cnt_clr_o, osc_run_o, asleep_o;
  int n_mismatch = 0;
  int compares = 0;
  // rows run back to back, so the accumulator carries between them
  csx_row_t rows [9] = '{
    '{CSX_OP_SUBL, 8'h00, 1'b0, 8'h00, 8'h00, 3'h7, 1'b0, 8'h00},
    '{CSX_OP_XORL, 8'hA5, 1'b0, 8'h00, 8'hA5, 3'h6, 1'b0, 8'h00},
    '{CSX_OP_SUBL, 8'h05, 1'b0, 8'h00, 8'h60, 3'h2, 1'b0, 8'h00},
    '{CSX_OP_SWAP, 8'h00, 1'b0, 8'h3C, 8'hC3, 3'h2, 1'b0, 8'h00},
    '{CSX_OP_XORF, 8'h00, 1'b0, 8'hC3, 8'h00, 3'h3, 1'b0, 8'h00},
    '{CSX_OP_XORF, 8'h00, 1'b1, 8'hFF, 8'h00, 3'h2, 1'b1, 8'hFF},
    '{CSX_OP_SWAP, 8'h00, 1'b1, 8'h12, 8'h00, 3'h2, 1'b1, 8'h21},
    '{CSX_OP_SUBL, 8'h01, 1'b0, 8'h00, 8'h01, 3'h6, 1'b0, 8'h00},
    '{CSX_OP_SUBL, 8'h00, 1'b0, 8'h00, 8'hFF, 3'h0, 1'b0, 8'h00}};
  // sleep-side outputs packed for one compare
  assign st = {3'h0, cnt_clr_o, expiry_flag_o, sleep_entry_flag_o,
    asleep_o, osc_run_o};
  always #4 clk_i = ~clk_i;
  csx_exec dut (.clk_i(clk_i), .nrst_i(nrst_i), .valid_i(valid_i),
    .op_i(op_i), .lit_i(lit_i), .dest_i(dest_i), .faddr_i(faddr_i),
    .fdata_i(fdata_i), .wake_i(wake_i), .acc_o(acc_o), .fwr_o(fwr_o),
    .fwaddr_o(fwaddr_o), .fwdata_o(fwdata_o), .carry_o(carry_o),
    .nibble_overflow_bit_o(nibble_overflow_bit_o), .zero_o(zero_o),
    .expiry_flag_o(expiry_flag_o), .sleep_entry_flag_o(sleep_entry_flag_o),
    .cnt_clr_o(cnt_clr_o), .osc_run_o(osc_run_o), .asleep_o(asleep_o));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_row(input csx_row_t r);
    chk(acc_o, r.acc);
    chk({5'h00, carry_o, nibble_overflow_bit_o, zero_o}, {5'h00, r.f});
    chk({7'h00, fwr_o}, {7'h00, r.w});
    if (r.w) chk({1'b0, fwaddr_o}, {1'b0, r.fd[6:0]});
    if (r.w) chk(fwdata_o, r.wd);
  endtask
  // one instruction alone, checked just after the edge that takes it
  task automatic do_op(input logic [2:0] op, input logic [7:0] lit);
    @(posedge clk_i);
    valid_i <= 1'b1;
    op_i <= op;
    lit_i <= lit;
    dest_i <= 1'b0;
    @(posedge clk_i);
    valid_i <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog: the whole run is under a hundred cycles
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    nrst_i = 1'b0;
    valid_i = 1'b0;
    op_i = 3'h0;
    lit_i = 8'h00;
    dest_i = 1'b0;
    faddr_i = 7'h00;
    fdata_i = 8'h00;
    wake_i = 1'b0;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1 chk(st, 8'h0D);
    chk(acc_o, CSX_ACC_RST);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      valid_i <= 1'b1;
      op_i <= rows[i].op;
      lit_i <= rows[i].lit;
      dest_i <= rows[i].d;
      fdata_i <= rows[i].fd;
      faddr_i <= rows[i].fd[6:0];
      #1 if (i > 0) chk_row(rows[i-1]);
    end
    @(posedge clk_i);
    valid_i <= 1'b0;
    #1 chk_row(rows[8]);
    // sleep, a refused instruction, then wake-up
    do_op(CSX_OP_SLEEP, 8'h00);
    chk(st, 8'h1A);
    chk({5'h00, carry_o, nibble_overflow_bit_o, zero_o}, 8'h00);
    do_op(CSX_OP_XORL, 8'h5A);
    chk(acc_o, 8'hFF);
    chk(st, 8'h0A);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    #1 chk(st, 8'h09);
    do_op(CSX_OP_XORL, 8'hFF);
    chk({acc_o[7:1], zero_o}, 8'h01);
    // sleep again with the zero flag up: flags must survive
    do_op(CSX_OP_SLEEP, 8'h00);
    chk({5'h00, carry_o, nibble_overflow_bit_o, zero_o}, 8'h01);
    chk(st, 8'h1A);
    // reset in mid-run brings back the reset values
    @(posedge clk_i);
    nrst_i <= 1'b0;
    #1 chk(st, 8'h0D);
    chk(acc_o, 8'h00);
    // release again: first instruction runs normally
    @(posedge clk_i);
    nrst_i <= 1'b1;
    do_op(CSX_OP_XORL, 8'h3C);
    chk({acc_o, 7'h00, zero_o}, 16'h3C00);
    tally_and_finish();
  end
endmodule // tb_top
